// [bench/csd_cam_model.sv]
`timescale 1ns/100ps
`default_nettype none
module csd_cam_model (
  input  wire logic       lane_clk,
  output var  logic       lane_dp_lp,
  output var  logic       lane_dn_lp,
  output var  logic       esc_bit_stb,
  output var  logic       esc_bit,
  output var  logic       hs_byte_vld,
  output var  logic [7:0] hs_byte
);
  // Lane idles in stop state; data lines show junk when not qualified
  initial begin
    lane_dp_lp  = 1'b1;
    lane_dn_lp  = 1'b1;
    esc_bit_stb = 1'b0;
    esc_bit     = 1'b1;
    hs_byte_vld = 1'b0;
    hs_byte     = 8'h5a;
  end

  task automatic set_line(input logic [1:0] st, input int hold);
    @(posedge lane_clk);
    {lane_dp_lp, lane_dn_lp} <= st;
    repeat (hold) @(posedge lane_clk);
  endtask : set_line

  // Bits go out msb first, one per lane cycle
  task automatic esc_send(input logic [7:0] val, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge lane_clk);
      esc_bit_stb <= 1'b1;
      esc_bit     <= val[i];
    end
    @(posedge lane_clk);
    esc_bit_stb <= 1'b0;
    esc_bit     <= ~esc_bit;
  endtask : esc_send

  task automatic hs_send(input logic [7:0] b);
    @(posedge lane_clk);
    hs_byte_vld <= 1'b1;
    hs_byte     <= b;
    @(posedge lane_clk);
    hs_byte_vld <= 1'b0;
    hs_byte     <= ~b;
  endtask : hs_send
endmodule : csd_cam_model
`default_nettype wire

// [bench/csd_lane_status_test.sv]
`timescale 1ns/100ps
`default_nettype none
module csd_lane_status_test;
  import csd_pkg::*;
  logic       clock;
  logic       sys_rst;
  logic       lane_clk;
  logic       lane_dp_lp;
  logic       lane_dn_lp;
  logic       esc_bit_stb;
  logic       esc_bit;
  logic       hs_byte_vld;
  logic [7:0] hs_byte;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rd_ack;
  logic       lane_protocol_select;
  int         error_cnt;
  int         comparisons;
  logic [7:0] bad_b [2] = '{8'hb9, 8'h47};
  logic [7:0] bad_e [2] = '{8'h01, 8'h02};
  logic [7:0] trig  [4] = '{CSD_CMD_TRIG_0, CSD_CMD_TRIG_1, CSD_CMD_TRIG_2, CSD_CMD_TRIG_3};

  csd_lane_status i_dut (
    .clock(clock), .sys_rst(sys_rst), .lane_clk(lane_clk), .lane_dp_lp(lane_dp_lp),
    .lane_dn_lp(lane_dn_lp), .esc_bit_stb(esc_bit_stb), .esc_bit(esc_bit), .hs_byte_vld(hs_byte_vld),
    .hs_byte(hs_byte), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack), .lane_protocol_select(lane_protocol_select)
  );
  csd_cam_model i_cam (
    .lane_clk(lane_clk), .lane_dp_lp(lane_dp_lp), .lane_dn_lp(lane_dn_lp), .esc_bit_stb(esc_bit_stb),
    .esc_bit(esc_bit), .hs_byte_vld(hs_byte_vld), .hs_byte(hs_byte)
  );

  always #4 clock = ~clock;
  always #40 lane_clk = ~lane_clk;

  task automatic print_verdict();
    $display("comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
    comparisons++;
    if ((got & mask) !== (exp & mask)) begin
      error_cnt++;
      $display("wrong value at %0t: register got %h expected %h mask %h", $time, got, exp, mask);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask : check1

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : write_reg

  // Answer is due exactly one cycle after the read edge
  task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check1(reg_rd_ack, 1'b1, "read ack");
    check8(reg_rdata, exp, mask);
  endtask : expect_reg

  // Covers line sync plus the crossing into the register clock
  task automatic settle();
    repeat (100) @(posedge clock);
  endtask : settle

  task automatic esc_entry();
    i_cam.set_line(2'h2, 6);
    i_cam.set_line(2'h0, 6);
    i_cam.set_line(2'h1, 6);
    i_cam.set_line(2'h0, 6);
  endtask : esc_entry

  task automatic hs_burst(input logic [7:0] b, input logic [1:0] last);
    i_cam.set_line(2'h1, 6);
    i_cam.set_line(2'h0, 6);
    i_cam.hs_send(b);
    i_cam.set_line(last, 6);
    settle();
  endtask : hs_burst

  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    clock = 1'b0;
    lane_clk = 1'b0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    // Lane reset passes a synchroniser, so hold well past 4 cycles
    repeat (64) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    expect_reg(CSD_OFS_LANE_STAT, 8'h00, 8'hff);
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'hff);
    expect_reg(CSD_OFS_PROTO_SEL, 8'h00, 8'hff);
    expect_reg(8'h20, 8'h00, 8'hff);
    check1(lane_protocol_select, 1'b0, "select");
    write_reg(CSD_OFS_PROTO_SEL, 8'hff);
    write_reg(CSD_OFS_LANE_STAT, 8'hff);
    write_reg(CSD_OFS_PROTO_ERR, 8'hff);
    check1(lane_protocol_select, 1'b1, "select");
    expect_reg(CSD_OFS_PROTO_SEL, 8'h0f, 8'hff);
    settle();
    expect_reg(CSD_OFS_LANE_STAT, 8'h01, 8'hff);
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'hc0);
    esc_entry();
    i_cam.esc_send(CSD_CMD_ULPS, 8);
    settle();
    expect_reg(CSD_OFS_LANE_STAT, 8'h02, 8'hff);
    i_cam.set_line(2'h2, 6);
    settle();
    expect_reg(CSD_OFS_LANE_STAT, 8'h00, 8'hff);
    i_cam.set_line(2'h3, 6);
    settle();
    expect_reg(CSD_OFS_LANE_STAT, 8'h01, 8'hff);
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'hff);
    hs_burst(CSD_HS_SYNC, 2'h3);
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'hff);
    for (int k = 0; k < 2; k++) begin
      hs_burst(bad_b[k], 2'h3);
      expect_reg(CSD_OFS_PROTO_ERR, bad_e[k], 8'hff);
      expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'hff);
    end
    hs_burst(CSD_HS_SYNC, 2'h2);
    i_cam.set_line(2'h3, 6);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h04, 8'h07);
    i_cam.set_line(2'h0, 6);
    i_cam.set_line(2'h3, 6);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h20, 8'h3f);
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'h20);
    i_cam.set_line(2'h2, 6);
    i_cam.set_line(2'h0, 6);
    i_cam.set_line(2'h3, 6);
    settle();
    expect_reg(CSD_OFS_LANE_STAT, 8'h01, 8'hff);
    expect_reg(CSD_OFS_PROTO_ERR, 8'h20, 8'hff);
    esc_entry();
    i_cam.esc_send(8'hff, 8);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h08, 8'h18);
    i_cam.set_line(2'h3, 6);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'h08);
    for (int k = 0; k < 4; k++) begin
      esc_entry();
      i_cam.esc_send(trig[k], 8);
      settle();
      expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'h08);
      i_cam.set_line(2'h3, 6);
    end
    esc_entry();
    i_cam.esc_send(CSD_CMD_LPDT, 8);
    i_cam.esc_send(8'h5a, 8);
    i_cam.set_line(2'h3, 6);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'h18);
    esc_entry();
    i_cam.esc_send(CSD_CMD_LPDT, 8);
    i_cam.esc_send(8'ha5, 3);
    i_cam.set_line(2'h3, 6);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h10, 8'h18);
    i_cam.set_line(2'h2, 6);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'h10);
    i_cam.set_line(2'h3, 6);
    settle();
    write_reg(CSD_OFS_PROTO_SEL, 8'h00);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'hff);
    check1(lane_protocol_select, 1'b0, "select");
    expect_reg(CSD_OFS_LANE_STAT, 8'h00, 8'hff);
    i_cam.set_line(2'h0, 6);
    i_cam.set_line(2'h3, 6);
    settle();
    expect_reg(CSD_OFS_PROTO_ERR, 8'h00, 8'hff);
    print_verdict();
  end
endmodule : csd_lane_status_test
`default_nettype wire

// [verilog/csd_hs_sot.sv]
`timescale 1ns/100ps
`default_nettype none
module csd_hs_sot (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       armed,
  input  wire logic       byte_vld,
  input  wire logic [7:0] byte_in,
  output logic            start_fault,
  output logic            start_sync_fault
);
  import csd_pkg::*;

  typedef struct packed {
    logic start_fault;
    logic start_sync_fault;
  } csd_sot_st_t;

  csd_sot_st_t so_r;
  csd_sot_st_t so_nxt;

  function automatic logic [3:0] csd_bit_diffs(input logic [7:0] a, input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, a[i] ^ b[i]};
    end
    return n;
  endfunction : csd_bit_diffs

  logic [3:0] diffs;

  always_comb begin
    so_nxt = '0;
    diffs  = csd_bit_diffs(byte_in, CSD_HS_SYNC);
    if (armed && byte_vld) begin
      // One flipped bit still locks; more means no lock
      so_nxt.start_fault      = (diffs == 4'h1);
      so_nxt.start_sync_fault = (diffs > 4'h1);
    end
    if (rst) begin
      so_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    so_r <= so_nxt;
  end

  assign start_fault      = so_r.start_fault;
  assign start_sync_fault = so_r.start_sync_fault;

endmodule : csd_hs_sot
`default_nettype wire

// [verilog/csd_lane_status.sv]
`timescale 1ns/100ps
`default_nettype none
// What this block does
// (R1) Offset 0x07 is a read-only lane status register whose bits 7:2 always read zero.
// (R2) Bit 1 of the status register reads 1 once the lane sits in ultra-low-power state, else 0.
// (R3) Bit 0 of the status register is 1 while the lane is in stop state and 0 after reset.
// (R4) Offset 0x0c is a read-only protocol error register with bits 7:6 zero and all bits zero after reset.
// (R5) Bit 5 of the error register reports a wrong sequence of line states.
// (R6) Bit 4 is raised when low-power data ends on a partial byte and held until the line state next changes.
// (R7) Bit 3 is raised on an unknown escape entry command and held until the line state next changes.
// (R8) Bit 2 reports a fault in the high-speed end-of-transmission sequence.
// (R9) Bit 1 reports failure to lock onto the high-speed start sequence.
// (R10) Bit 0 reports an error in the high-speed start sequence.
// (R11) Bit 0 of register 0x06 picks the lane protocol, 0 for the serial camera port and 1 for CSI.
// (R12) Lane flags reach the register clock through synchronisers before software reads them.
module csd_lane_status (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       lane_clk,
  input  wire logic       lane_dp_lp,
  input  wire logic       lane_dn_lp,
  input  wire logic       esc_bit_stb,
  input  wire logic       esc_bit,
  input  wire logic       hs_byte_vld,
  input  wire logic [7:0] hs_byte,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_ack,
  output logic            lane_protocol_select
);
  import csd_pkg::*;

  // Lane clock domain state
  typedef struct packed {
    csd_lane_st_t st;
    logic [1:0]   ls_prev;
    logic [2:0]   bit_cnt;
    logic [7:0]   cmd;
    logic         sot_armed;
    logic         stop;
    logic         ulp;
    logic         esc_sync_err;
    logic         esc_cmd_err;
    logic [3:0]   tog;
  } csd_lane_t;

  // Register clock domain state
  typedef struct packed {
    logic [3:0] sel;
    logic [3:0] tog_seen;
    logic [3:0] evt;
    logic [7:0] rdata;
    logic       rd_ack;
  } csd_regs_t;

  csd_lane_t ln_r;
  csd_lane_t ln_nxt;
  csd_regs_t rg_r;
  csd_regs_t rg_nxt;

  logic       lane_rst;
  logic [2:0] lane_in;
  logic [1:0] ls;
  logic       sel_csi;
  logic       sot_fault;
  logic       sot_sync_fault;
  logic [7:0] from_lane;
  logic [3:0] lvl_sync;
  logic [3:0] tog_sync;

  // Reset into the lane domain
  csd_sync #(.W(1)) u_rst_sync (
    .clock (lane_clk),
    .rst   (1'b0),
    .din   (sys_rst),
    .dout  (lane_rst)
  );

  // Line pins and protocol choice into the lane domain
  csd_sync #(.W(3)) u_lane_sync (
    .clock (lane_clk),
    .rst   (lane_rst),
    .din   ({rg_r.sel[CSD_SEL_PROTO_BIT], lane_dp_lp, lane_dn_lp}),
    .dout  (lane_in)
  );

  assign ls      = lane_in[1:0];
  assign sel_csi = lane_in[2];

  csd_hs_sot u_hs_sot (
    .clock            (lane_clk),
    .rst              (lane_rst),
    .armed            (ln_r.sot_armed),
    .byte_vld         (hs_byte_vld),
    .byte_in          (hs_byte),
    .start_fault      (sot_fault),
    .start_sync_fault (sot_sync_fault)
  );

  logic       ls_chg;
  logic       seq_err;
  logic [7:0] cmd_new;

  always_comb begin
    ln_nxt         = ln_r;
    seq_err        = 1'b0;
    cmd_new        = {ln_r.cmd[6:0], esc_bit};
    ls_chg         = (ls != ln_r.ls_prev);
    ln_nxt.ls_prev = ls;
    if (ls_chg) begin
      ln_nxt.esc_sync_err = 1'b0;  // [R6]
      ln_nxt.esc_cmd_err  = 1'b0;  // [R7]
    end
    if (hs_byte_vld) begin
      ln_nxt.sot_armed = 1'b0;
    end
    if (sot_fault) begin
      ln_nxt.tog[CSD_EV_SOT] = ~ln_r.tog[CSD_EV_SOT];  // [R10]
    end
    if (sot_sync_fault) begin
      ln_nxt.tog[CSD_EV_SOT_SYNC] = ~ln_r.tog[CSD_EV_SOT_SYNC];  // [R9]
    end
    case (ln_r.st)
      ST_STOP: begin
        if (ls_chg) begin
          if (ls == CSD_LP_HS_RQST) begin
            ln_nxt.st = ST_HS_RQST;
          end else if (ls == CSD_LP_RQST) begin
            ln_nxt.st = ST_LP_RQST;
          end else begin
            seq_err = 1'b1;
          end
        end
      end
      ST_HS_RQST: begin
        if (ls_chg) begin
          if (ls == CSD_LP_BRIDGE) begin
            ln_nxt.st        = ST_HS;
            ln_nxt.sot_armed = 1'b1;
          end else if (ls == CSD_LP_STOP) begin
            ln_nxt.st = ST_STOP;
          end else begin
            seq_err = 1'b1;
          end
        end
      end
      ST_HS: begin
        if (ls_chg) begin
          ln_nxt.sot_armed = 1'b0;
          if (ls == CSD_LP_STOP) begin
            ln_nxt.st = ST_STOP;
          end else begin
            // Burst must close straight into stop
            ln_nxt.tog[CSD_EV_EOT] = ~ln_r.tog[CSD_EV_EOT];  // [R8]
            ln_nxt.st              = ST_SKIP;
          end
        end
      end
      ST_LP_RQST: begin
        if (ls_chg) begin
          if (ls == CSD_LP_BRIDGE) begin
            ln_nxt.st = ST_LP_YIELD;
          end else if (ls == CSD_LP_STOP) begin
            ln_nxt.st = ST_STOP;
          end else begin
            seq_err = 1'b1;
          end
        end
      end
      ST_LP_YIELD: begin
        if (ls_chg) begin
          if (ls == CSD_LP_HS_RQST) begin
            ln_nxt.st = ST_ESC_RQST;
          end else begin
            seq_err = 1'b1;
          end
        end
      end
      ST_ESC_RQST: begin
        if (ls_chg) begin
          if (ls == CSD_LP_BRIDGE) begin
            ln_nxt.st      = ST_ESC_CMD;
            ln_nxt.bit_cnt = 3'h0;
          end else begin
            seq_err = 1'b1;
          end
        end
      end
      ST_ESC_CMD, ST_LPDT, ST_ULPS, ST_ESC_WAIT: begin
        if (ls_chg && (ls == CSD_LP_STOP)) begin
          ln_nxt.st = ST_STOP;
          if ((ln_r.st == ST_LPDT) && (ln_r.bit_cnt != 3'h0)) begin
            ln_nxt.esc_sync_err = 1'b1;  // [R6]
          end
        end else if (esc_bit_stb && (ln_r.st == ST_ESC_CMD)) begin
          ln_nxt.cmd     = cmd_new;
          ln_nxt.bit_cnt = ln_r.bit_cnt + 3'h1;
          if (ln_r.bit_cnt == 3'h7) begin
            if (cmd_new == CSD_CMD_LPDT) begin
              ln_nxt.st = ST_LPDT;
            end else if (cmd_new == CSD_CMD_ULPS) begin
              ln_nxt.st = ST_ULPS;
            end else if (csd_is_trigger(cmd_new)) begin
              ln_nxt.st = ST_ESC_WAIT;
            end else begin
              ln_nxt.esc_cmd_err = 1'b1;  // [R7]
              ln_nxt.st          = ST_ESC_WAIT;
            end
          end
        end else if (esc_bit_stb && (ln_r.st == ST_LPDT)) begin
          ln_nxt.bit_cnt = ln_r.bit_cnt + 3'h1;
        end
      end
      ST_SKIP: begin
        if (ls_chg && (ls == CSD_LP_STOP)) begin
          ln_nxt.st = ST_STOP;
        end
      end
      default: begin
        ln_nxt.st = ST_STOP;
      end
    endcase
    if (seq_err) begin
      // A fault that lands on stop resyncs at once
      ln_nxt.st                  = (ls == CSD_LP_STOP) ? ST_STOP : ST_SKIP;
      ln_nxt.tog[CSD_EV_CONTROL] = ~ln_r.tog[CSD_EV_CONTROL];  // [R5]
    end
    ln_nxt.stop = (ln_nxt.st == ST_STOP) && (ls == CSD_LP_STOP);  // [R3]
    // Mark-1 means leaving, so the flag drops there already
    ln_nxt.ulp  = (ln_nxt.st == ST_ULPS) && (ls == CSD_LP_BRIDGE);  // [R2]
    if (!sel_csi) begin
      // Serial camera port mode: CSI monitor idles
      ln_nxt.st           = ST_STOP;  // [R11]
      ln_nxt.sot_armed    = 1'b0;
      ln_nxt.stop         = 1'b0;
      ln_nxt.ulp          = 1'b0;
      ln_nxt.esc_sync_err = 1'b0;
      ln_nxt.esc_cmd_err  = 1'b0;
      ln_nxt.tog          = ln_r.tog;
    end
    if (lane_rst) begin
      ln_nxt    = '0;
      ln_nxt.st = ST_STOP;
    end
  end

  always_ff @(posedge lane_clk) begin
    ln_r <= ln_nxt;
  end

  // Lane flags into the register domain
  csd_sync #(.W(8)) u_reg_sync (
    .clock (clock),
    .rst   (sys_rst),
    .din   ({ln_r.tog, ln_r.esc_sync_err, ln_r.esc_cmd_err, ln_r.ulp, ln_r.stop}),
    .dout  (from_lane)
  );  // [R12]

  assign lvl_sync = from_lane[3:0];
  assign tog_sync = from_lane[7:4];

  logic [7:0] stat_val;
  logic [7:0] err_val;
  logic [3:0] new_evt;

  always_comb begin
    rg_nxt          = rg_r;
    new_evt         = tog_sync ^ rg_r.tog_seen;
    rg_nxt.tog_seen = tog_sync;
    stat_val        = CSD_RST_LANE_STAT;  // [R1]
    stat_val[CSD_STAT_ULP_BIT]  = lvl_sync[1];
    stat_val[CSD_STAT_STOP_BIT] = lvl_sync[0];
    err_val         = CSD_RST_PROTO_ERR;  // [R4]
    err_val[CSD_ERR_CONTROL_BIT]  = rg_r.evt[CSD_EV_CONTROL];
    err_val[CSD_ERR_SYNC_ESC_BIT] = lvl_sync[3];
    err_val[CSD_ERR_ESC_BIT]      = lvl_sync[2];
    err_val[CSD_ERR_EOT_BIT]      = rg_r.evt[CSD_EV_EOT];
    err_val[CSD_ERR_SOT_SYNC_BIT] = rg_r.evt[CSD_EV_SOT_SYNC];
    err_val[CSD_ERR_SOT_BIT]      = rg_r.evt[CSD_EV_SOT];
    rg_nxt.rd_ack   = reg_rd;
    if (reg_rd) begin
      if (reg_addr == CSD_OFS_PROTO_SEL) begin
        rg_nxt.rdata = {4'h0, rg_r.sel};
      end else if (reg_addr == CSD_OFS_LANE_STAT) begin
        rg_nxt.rdata = stat_val;
      end else if (reg_addr == CSD_OFS_PROTO_ERR) begin
        rg_nxt.rdata = err_val;
        rg_nxt.evt   = 4'h0;
      end else begin
        rg_nxt.rdata = 8'h00;
      end
    end
    // New events win over the clear on read
    rg_nxt.evt = rg_nxt.evt | new_evt;  // [R5] [R8] [R9] [R10]
    if (reg_wr && (reg_addr == CSD_OFS_PROTO_SEL)) begin
      rg_nxt.sel = reg_wdata[3:0];  // [R11]
    end
    if (sys_rst) begin
      rg_nxt     = '0;
      rg_nxt.sel = CSD_RST_PROTO_SEL;
    end
  end

  always_ff @(posedge clock) begin
    rg_r <= rg_nxt;
  end

  assign reg_rdata            = rg_r.rdata;
  assign reg_rd_ack           = rg_r.rd_ack;
  assign lane_protocol_select = rg_r.sel[CSD_SEL_PROTO_BIT];

  a_stat_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)  // [R1]
    (reg_rd && (reg_addr == CSD_OFS_LANE_STAT)) |=> (reg_rd_ack && (reg_rdata[7:2] == 6'h00)))
    else $error("status reserved bits not zero");

  a_ulp_flag_set: assert property (@(posedge lane_clk) disable iff (lane_rst)  // [R2]
    (sel_csi && (ln_r.st == ST_ULPS) && !ls_chg && (ls == CSD_LP_BRIDGE)) |=> ln_r.ulp)
    else $error("ulp flag missing in ulp state");

  a_stop_flag_track: assert property (@(posedge lane_clk) disable iff (lane_rst)  // [R3]
    ln_r.stop |-> ((ln_r.st == ST_STOP) && $past(sel_csi) && ($past(ls) == CSD_LP_STOP)))
    else $error("stop flag without stop state");

  a_err_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)  // [R4]
    (reg_rd && (reg_addr == CSD_OFS_PROTO_ERR)) |=> (reg_rdata[7:6] == 2'h0))
    else $error("error reserved bits not zero");

  a_seq_err_event: assert property (@(posedge lane_clk) disable iff (lane_rst)  // [R5]
    (sel_csi && (ln_r.st == ST_STOP) && ls_chg && (ls == CSD_LP_BRIDGE))
      |=> ($changed(ln_r.tog[CSD_EV_CONTROL]) && (ln_r.st == ST_SKIP)))
    else $error("bad line sequence not reported");

  a_esc_sync_hold: assert property (@(posedge lane_clk) disable iff (lane_rst)  // [R6]
    (ln_r.esc_sync_err && !ls_chg && sel_csi) |=> ln_r.esc_sync_err)
    else $error("escape sync flag dropped early");

  a_esc_cmd_flag: assert property (@(posedge lane_clk) disable iff (lane_rst)  // [R7]
    (sel_csi && (ln_r.st == ST_ESC_CMD) && esc_bit_stb && !ls_chg && (ln_r.bit_cnt == 3'h7)
      && (cmd_new != CSD_CMD_LPDT) && (cmd_new != CSD_CMD_ULPS) && !csd_is_trigger(cmd_new))
      |=> (ln_r.esc_cmd_err && (ln_r.st == ST_ESC_WAIT)))
    else $error("unknown escape command not flagged");

  a_eot_fault_event: assert property (@(posedge lane_clk) disable iff (lane_rst)  // [R8]
    (sel_csi && (ln_r.st == ST_HS) && ls_chg && (ls != CSD_LP_STOP)) |=> $changed(ln_r.tog[CSD_EV_EOT]))
    else $error("end sequence fault not reported");

  a_sot_fault_event: assert property (@(posedge lane_clk) disable iff (lane_rst)  // [R10]
    (sot_fault && sel_csi) |=> $changed(ln_r.tog[CSD_EV_SOT]))
    else $error("start fault not reported");

  a_proto_sel_write: assert property (@(posedge clock) disable iff (sys_rst)  // [R11]
    (reg_wr && (reg_addr == CSD_OFS_PROTO_SEL)) |=> (lane_protocol_select == $past(reg_wdata[0])))
    else $error("protocol select not written");

  a_evt_reaches_reg: assert property (@(posedge clock) disable iff (sys_rst)  // [R12]
    (new_evt[CSD_EV_CONTROL]) |=> rg_r.evt[CSD_EV_CONTROL])
    else $error("crossed event lost");

endmodule : csd_lane_status
`default_nettype wire

// [verilog/csd_pkg.sv]
`default_nettype none
package csd_pkg;

  // Register offsets
  localparam logic [7:0] CSD_OFS_PROTO_SEL = 8'h06;
  localparam logic [7:0] CSD_OFS_LANE_STAT = 8'h07;
  localparam logic [7:0] CSD_OFS_PROTO_ERR = 8'h0c;

  // Reset values
  localparam logic [3:0] CSD_RST_PROTO_SEL = 4'h0;
  localparam logic [7:0] CSD_RST_LANE_STAT = 8'h00;
  localparam logic [7:0] CSD_RST_PROTO_ERR = 8'h00;

  // Field positions
  localparam int CSD_SEL_PROTO_BIT    = 0;
  localparam int CSD_STAT_STOP_BIT    = 0;
  localparam int CSD_STAT_ULP_BIT     = 1;
  localparam int CSD_ERR_SOT_BIT      = 0;
  localparam int CSD_ERR_SOT_SYNC_BIT = 1;
  localparam int CSD_ERR_EOT_BIT      = 2;
  localparam int CSD_ERR_ESC_BIT      = 3;
  localparam int CSD_ERR_SYNC_ESC_BIT = 4;
  localparam int CSD_ERR_CONTROL_BIT  = 5;

  // Event slots carried across domains by toggles
  localparam int CSD_EV_SOT      = 0;
  localparam int CSD_EV_SOT_SYNC = 1;
  localparam int CSD_EV_EOT      = 2;
  localparam int CSD_EV_CONTROL  = 3;

  // Low-power line states, {dp, dn}
  localparam logic [1:0] CSD_LP_STOP    = 2'h3;
  localparam logic [1:0] CSD_LP_HS_RQST = 2'h1;
  localparam logic [1:0] CSD_LP_RQST    = 2'h2;
  localparam logic [1:0] CSD_LP_BRIDGE  = 2'h0;

  // Escape entry commands, first received bit in the msb
  localparam logic [7:0] CSD_CMD_LPDT   = 8'he1;
  localparam logic [7:0] CSD_CMD_ULPS   = 8'h1e;
  localparam logic [7:0] CSD_CMD_TRIG_0 = 8'h62;
  localparam logic [7:0] CSD_CMD_TRIG_1 = 8'h5d;
  localparam logic [7:0] CSD_CMD_TRIG_2 = 8'h21;
  localparam logic [7:0] CSD_CMD_TRIG_3 = 8'ha0;

  // High-speed leader byte
  localparam logic [7:0] CSD_HS_SYNC = 8'hb8;

  typedef enum logic [3:0] {
    ST_STOP, ST_HS_RQST, ST_HS, ST_LP_RQST, ST_LP_YIELD, ST_ESC_RQST,
    ST_ESC_CMD, ST_LPDT, ST_ULPS, ST_ESC_WAIT, ST_SKIP
  } csd_lane_st_t;

  function automatic logic csd_is_trigger(input logic [7:0] cmd);
    return (cmd == CSD_CMD_TRIG_0) || (cmd == CSD_CMD_TRIG_1) ||
           (cmd == CSD_CMD_TRIG_2) || (cmd == CSD_CMD_TRIG_3);
  endfunction : csd_is_trigger

endpackage : csd_pkg
`default_nettype wire

// [verilog/csd_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module csd_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import csd_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } csd_sync_st_t;

  csd_sync_st_t sy_r;
  csd_sync_st_t sy_nxt;

  always_comb begin
    sy_nxt    = sy_r;
    sy_nxt.s1 = din;
    sy_nxt.s2 = sy_r.s1;
    sy_nxt.s3 = sy_r.s2;
    // Bitwise: take a new value once stages two and three agree
    sy_nxt.q  = (sy_r.s2 & sy_r.s3) | (sy_r.q & (sy_r.s2 | sy_r.s3));
    if (rst) begin
      sy_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    sy_r <= sy_nxt;
  end

  assign dout = sy_r.q;

endmodule : csd_sync
`default_nettype wire
